/* hdl/atx_defs.vh */
// register map, field positions, reset values and timing for the transmit and interrupt block
`ifndef ATX_DEFS_VH
`define ATX_DEFS_VH

// register word addresses on the 11-bit host address
`define ATX_A_CTRL1   11'h000
`define ATX_A_CTRL2   11'h001
`define ATX_A_STAT    11'h002
`define ATX_A_TX0_LO  11'h003
`define ATX_A_TX0_HI  11'h004
`define ATX_A_TX1_LO  11'h005
`define ATX_A_TX1_HI  11'h006
`define ATX_A_IMASK   11'h007
`define ATX_A_IMODE   11'h008
`define ATX_A_ISTAT1  11'h009
`define ATX_A_ISTAT2  11'h00a
`define ATX_A_ISTAT3  11'h00b
`define ATX_A_IROUTE  11'h00c
`define ATX_A_ERR     11'h00d

// address bit that selects the shared memory window
`define ATX_MEM_BIT   10

// first control register field bases (one bit per channel)
`define ATX_C1_HS     0
`define ATX_C1_WRAP   2
`define ATX_C1_NOPAR  4

// reset values
`define ATX_CTRL1_RST  6'h00
`define ATX_CTRL2_RST  2'h3
`define ATX_IMASK_RST  3'h0
`define ATX_IMODE_RST  3'h0
`define ATX_IROUTE_RST 4'h0

// bit clock cycles per serial bit
`define ATX_DIV_HS    7'h0a
`define ATX_DIV_LS    7'h50
// idle bit times between words
`define ATX_GAP_BITS  3'h4

// pulse interrupt width
`define ATX_PULSE_NS  1000
`define ATX_CLK_KHZ   20000
`define ATX_PULSE_CYC ((`ATX_PULSE_NS * `ATX_CLK_KHZ + 999999) / 1000000)

`endif

/* hdl/atx_tx_irq.v */
// two-channel serial transmitter, interrupt controller and zero-wait read path
`timescale 1ns/1ps
`include "atx_defs.vh"
// What this block does
// - each channel picks its own rate bit
// - one bit per 10 or 80 bit clocks
// - each channel owns 32x32 word queue
// - disable holds channel; low sends queued words
// - one queue-empty status flag per channel
// - wraparound loops tx into receive pairs
// - receive one and three see inverted data
// - odd parity unless parity override set
// - 8/16-bit bus, two strobe styles
// - three routable outputs plus unmaskable error
// - error low while any error bit set
// - input error bits clear on read or removal, overflow bits on read only
// - any source to any output, zero off
// - each output level or pulse mode
// - pulse mode low for one microsecond
// - level holds until status read clears
// - mask gates pin only, status still latches
// - unmasking in level mode asserts at once
// - zero-wait active while strap not grounded
// - priming read latches word, pieces follow
// - match route 00 raises no interrupt
module atx_tx_irq #(
    parameter FIFO_AW = 5                       // log2 of queue depth
) (
    input  wire        clock_i,                 // 20 MHz system clock
    input  wire        nrst_i,                  // async reset, active low
    input  wire [10:0] host_addr_i,             // host address
    input  wire [15:0] host_wdata_i,            // host write data
    input  wire        host_wr_i,               // write strobe or rd/wr line
    input  wire        host_rd_i,               // read strobe or data strobe
    output wire [15:0] host_rdata_o,            // read data, cycle after read
    input  wire        strobe_style_i,          // strap: 1 = data strobe style
    input  wire        bus_8bit_i,              // strap: 1 = 8-bit host
    input  wire        zero_wait_i,             // strap: high = zero-wait mode
    input  wire [1:0]  arinc_clk_i,             // per-channel bit clocks
    output wire [1:0]  tx_hi_o,                 // line driver high leg
    output wire [1:0]  tx_lo_o,                 // line driver low leg
    output wire [3:0]  wrap_hi_o,               // looped data, high leg
    output wire [3:0]  wrap_lo_o,               // looped data, low leg
    input  wire        match_i,                 // match event pulse
    input  wire [1:0]  match_route_i,           // route bits of matched entry
    input  wire [3:0]  error_i,                 // external error conditions
    output wire        mem_rd_o,                // shared memory fetch strobe
    output wire [9:0]  mem_addr_o,              // shared memory word address
    input  wire [31:0] mem_data_i,              // memory word, same cycle
    output wire [2:0]  irq_n_o,                 // general outputs 1..3, low
    output wire        error_n_o                // error output, low active
);

    localparam ST_IDLE = 3'b001;                // waiting for a word
    localparam ST_SEND = 3'b010;                // shifting 32 bits
    localparam ST_GAP  = 3'b100;                // interword idle
    localparam DEPTH   = 1 << FIFO_AW;          // words per queue
    localparam integer PULSE_CYC = `ATX_PULSE_CYC; // pulse width in clocks

    // odd parity in bit 31 unless override keeps the word as written
    function [31:0] atx_par;
        input [31:0] w;
        input        np;
        begin
            atx_par = np ? w : {~^w[30:0], w[30:0]};
        end
    endfunction

    // clocks per bit for the selected rate
    function [6:0] atx_div;
        input hs;
        begin
            atx_div = hs ? `ATX_DIV_HS : `ATX_DIV_LS;
        end
    endfunction

    // pick a byte or half word out of a 32-bit word
    function [15:0] atx_piece;
        input [31:0] w;
        input [1:0]  pc;
        input        b8;
        begin
            if (b8)
                atx_piece = {8'h00, w[pc*8 +: 8]};
            else
                atx_piece = pc[0] ? w[31:16] : w[15:0];
        end
    endfunction

    // route match: a route of zero never equals an output number
    function atx_hit;
        input [1:0] r;
        input [1:0] n;
        begin
            atx_hit = (r == n);
        end
    endfunction

    integer c;                                  // channel loop index
    integer k;                                  // output loop index
    integer j; // wrap loop index
    integer m; // route loop index

    // input synchronisers: first stage feeds only the second
    reg  [8:0]  sy1_r;                          // first stage
    reg  [8:0]  sy2_r;                          // second stage
    reg  [1:0]  clk_d_r;                        // bit clocks, delayed
    reg  [3:0]  err_d_r;                        // error inputs, delayed
    wire        sty = sy2_r[0];                 // strobe style
    wire        b8  = sy2_r[1];                 // 8-bit host
    wire        zw  = sy2_r[2];                 // zero-wait mode
    wire [3:0]  esy = sy2_r[6:3];               // error levels
    wire [1:0]  csy = sy2_r[8:7];               // bit clock levels
    wire [1:0]  ce  = csy & ~clk_d_r;           // bit clock rising edges

    // pins settle through two flops, edges read the second stage
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sy1_r   <= 9'h000;
            sy2_r   <= 9'h000;
            clk_d_r <= 2'h0;
            err_d_r <= 4'h0;
        end else begin
            sy1_r   <= {arinc_clk_i, error_i, zero_wait_i, bus_8bit_i, strobe_style_i};
            sy2_r   <= sy1_r;
            clk_d_r <= csy;
            err_d_r <= esy;
        end
    end

    // strobe style decode: style 1 uses data strobe plus read line
    wire rd_en = sty ? (host_rd_i & host_wr_i) : host_rd_i;
    wire wr_en = sty ? (host_rd_i & ~host_wr_i) : host_wr_i;
    wire [10:0] a = host_addr_i;                // short alias

    // software state
    reg  [5:0]  ctrl1_r;                        // rate, wrap, parity bits
    reg  [1:0]  ctrl2_r;                        // per-channel disable
    reg  [2:0]  imask_r;                        // output masks
    reg  [2:0]  imode_r;                        // 1 = pulse mode
    reg  [3:0]  iroute_r;                       // empty-event routes
    reg  [15:0] lo0_r;                          // staged low half, ch 0
    reg  [15:0] lo1_r;                          // staged low half, ch 1
    reg  [15:0] rdata_r;                        // read data register
    reg  [31:0] zlat_r;                         // zero-wait holding latch
    reg         primed_r;                       // latch holds a fetched word

    // queues: one array, channel in the top index bit
    reg  [31:0] tx_mem [0:2*DEPTH-1];
    reg  [FIFO_AW:0] wp [0:1];                  // write pointers
    reg  [FIFO_AW:0] rp [0:1];                  // read pointers
    wire [1:0]  empty;                          // queue empty
    wire [1:0]  full;                           // queue full
    assign empty[0] = (wp[0] == rp[0]);
    assign empty[1] = (wp[1] == rp[1]);
    assign full[0]  = (wp[0] == {~rp[0][FIFO_AW], rp[0][FIFO_AW-1:0]});
    assign full[1]  = (wp[1] == {~rp[1][FIFO_AW], rp[1][FIFO_AW-1:0]});

    // push on the high half write; a push into a full queue is dropped
    wire [1:0] push;                            // accepted pushes
    wire [1:0] ovf;                             // refused pushes
    assign push[0] = wr_en & (a == `ATX_A_TX0_HI) & ~full[0];
    assign push[1] = wr_en & (a == `ATX_A_TX1_HI) & ~full[1];
    assign ovf[0]  = wr_en & (a == `ATX_A_TX0_HI) & full[0];
    assign ovf[1]  = wr_en & (a == `ATX_A_TX1_HI) & full[1];

    // memory window decode and piece selection
    wire        mem_sel = a[`ATX_MEM_BIT];      // shared memory access
    wire [1:0]  pc   = b8 ? a[1:0] : {1'b0, a[0]};
    wire        last = b8 ? (pc == 2'h3) : (pc == 2'h1);    // final piece
    wire        prime = zw & (pc == 2'h0) & ~primed_r;
    assign mem_rd_o   = rd_en & mem_sel & (~zw | prime);
    assign mem_addr_o = b8 ? {2'h0, a[9:2]} : {1'b0, a[9:1]};

    // clear-on-read strobes
    wire [2:0] ist_clr;                         // status read per output
    assign ist_clr[0] = rd_en & (a == `ATX_A_ISTAT1);
    assign ist_clr[1] = rd_en & (a == `ATX_A_ISTAT2);
    assign ist_clr[2] = rd_en & (a == `ATX_A_ISTAT3);
    wire err_clr = rd_en & (a == `ATX_A_ERR);   // error status read

    reg  [2:0] st [0:1];                        // serializer state
    wire [1:0] busy;                            // word or gap in progress
    assign busy[0] = (st[0] != ST_IDLE);
    assign busy[1] = (st[1] != ST_IDLE);
    reg  [8:0] istat_r;                         // 3 bits per output
    reg  [5:0] err_r;                           // error status bits

    // queue writes; the array has no reset, so keep it apart
    always @(posedge clock_i) begin
        if (push[0])
            tx_mem[{1'b0, wp[0][FIFO_AW-1:0]}] <= {host_wdata_i, lo0_r};
        if (push[1])
            tx_mem[{1'b1, wp[1][FIFO_AW-1:0]}] <= {host_wdata_i, lo1_r};
    end

    // host writes, read mux and zero-wait latch
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl1_r  <= `ATX_CTRL1_RST;
            ctrl2_r  <= `ATX_CTRL2_RST;
            imask_r  <= `ATX_IMASK_RST;
            imode_r  <= `ATX_IMODE_RST;
            iroute_r <= `ATX_IROUTE_RST;
            lo0_r    <= 16'h0000;
            lo1_r    <= 16'h0000;
            rdata_r  <= 16'h0000;
            zlat_r   <= 32'h0000_0000;
            primed_r <= 1'b0;
            wp[0]    <= {(FIFO_AW+1){1'b0}};
            wp[1]    <= {(FIFO_AW+1){1'b0}};
        end else begin
            if (push[0])
                wp[0] <= wp[0] + 1'b1;
            if (push[1])
                wp[1] <= wp[1] + 1'b1;
            if (wr_en) begin
                if (a == `ATX_A_CTRL1) begin
                    ctrl1_r <= host_wdata_i[5:0];
                end else if (a == `ATX_A_CTRL2) begin
                    ctrl2_r <= host_wdata_i[1:0];
                end else if (a == `ATX_A_TX0_LO) begin
                    lo0_r <= host_wdata_i;
                end else if (a == `ATX_A_TX1_LO) begin
                    lo1_r <= host_wdata_i;
                end else if (a == `ATX_A_IMASK) begin
                    imask_r <= host_wdata_i[2:0];
                end else if (a == `ATX_A_IMODE) begin
                    imode_r <= host_wdata_i[2:0];
                end else if (a == `ATX_A_IROUTE) begin
                    iroute_r <= host_wdata_i[3:0];
                end
            end
            // unmapped reads and idle cycles return zero
            rdata_r <= 16'h0000;
            if (rd_en) begin
                if (mem_sel && !zw) begin
                    // direct path: word fetched and sliced in one go
                    rdata_r <= atx_piece(mem_data_i, pc, b8);
                end else if (mem_sel && prime) begin
                    // priming read: data only latched, host sees zero
                    zlat_r   <= mem_data_i;
                    primed_r <= 1'b1;
                end else if (mem_sel) begin
                    rdata_r <= atx_piece(zlat_r, pc, b8);
                    if (last)
                        primed_r <= 1'b0;
                end else if (a == `ATX_A_CTRL1) begin
                    rdata_r <= {10'h000, ctrl1_r};
                end else if (a == `ATX_A_CTRL2) begin
                    rdata_r <= {14'h0000, ctrl2_r};
                end else if (a == `ATX_A_STAT) begin
                    rdata_r <= {10'h000, busy, full, empty};
                end else if (a == `ATX_A_IMASK) begin
                    rdata_r <= {13'h0000, imask_r};
                end else if (a == `ATX_A_IMODE) begin
                    rdata_r <= {13'h0000, imode_r};
                end else if (a == `ATX_A_ISTAT1) begin
                    rdata_r <= {13'h0000, istat_r[2:0]};
                end else if (a == `ATX_A_ISTAT2) begin
                    rdata_r <= {13'h0000, istat_r[5:3]};
                end else if (a == `ATX_A_ISTAT3) begin
                    rdata_r <= {13'h0000, istat_r[8:6]};
                end else if (a == `ATX_A_IROUTE) begin
                    rdata_r <= {12'h000, iroute_r};
                end else if (a == `ATX_A_ERR) begin
                    rdata_r <= {10'h000, err_r};
                end
            end
            // leaving zero-wait mode forgets a half-read word
            if (!zw)
                primed_r <= 1'b0;
        end
    end
    assign host_rdata_o = rdata_r;

    // serializer state per channel
    reg  [6:0]  tick [0:1];                     // bit clocks into the bit
    reg  [4:0]  bitn [0:1];                     // bit being sent
    reg  [2:0]  gap  [0:1];                     // idle bits sent
    reg  [31:0] shr  [0:1];                     // shifting word
    reg  [1:0]  hi_r;                           // high leg
    reg  [1:0]  lo_r;                           // low leg
    wire [31:0] head [0:1];                     // queue head, parity fixed
    assign head[0] = atx_par(tx_mem[{1'b0, rp[0][FIFO_AW-1:0]}],
                             ctrl1_r[`ATX_C1_NOPAR]);
    assign head[1] = atx_par(tx_mem[{1'b1, rp[1][FIFO_AW-1:0]}],
                             ctrl1_r[`ATX_C1_NOPAR+1]);

    // return-to-zero serializer, low bit first; rate is read live,
    // so a rate change mid-word bends that word's timing
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (c = 0; c < 2; c = c + 1) begin
                st[c]   <= ST_IDLE;
                tick[c] <= 7'h00;
                bitn[c] <= 5'h00;
                gap[c]  <= 3'h0;
                shr[c]  <= 32'h0000_0000;
                rp[c]   <= {(FIFO_AW+1){1'b0}};
            end
            hi_r <= 2'h0;
            lo_r <= 2'h0;
        end else begin
            for (c = 0; c < 2; c = c + 1) begin
                if (ce[c]) begin
                    case (st[c])
                        ST_IDLE: begin
                            // disable only gates the start of a word
                            if (!ctrl2_r[c] && !empty[c]) begin
                                shr[c]  <= head[c];
                                hi_r[c] <= head[c][0];
                                lo_r[c] <= ~head[c][0];
                                rp[c]   <= rp[c] + 1'b1;
                                tick[c] <= 7'h00;
                                bitn[c] <= 5'h00;
                                st[c]   <= ST_SEND;
                            end
                        end
                        ST_SEND: begin
                            if (tick[c] == atx_div(ctrl1_r[c]) - 7'h01) begin
                                tick[c] <= 7'h00;
                                if (bitn[c] == 5'h1f) begin
                                    st[c]   <= ST_GAP;
                                    gap[c]  <= 3'h0;
                                    hi_r[c] <= 1'b0;
                                    lo_r[c] <= 1'b0;
                                end else begin
                                    bitn[c] <= bitn[c] + 5'h01;
                                    shr[c]  <= shr[c] >> 1;
                                    hi_r[c] <= shr[c][1];
                                    lo_r[c] <= ~shr[c][1];
                                end
                            end else begin
                                tick[c] <= tick[c] + 7'h01;
                                // second half of each bit is null
                                if (tick[c] == (atx_div(ctrl1_r[c]) >> 1) - 7'h01) begin
                                    hi_r[c] <= 1'b0;
                                    lo_r[c] <= 1'b0;
                                end
                            end
                        end
                        ST_GAP: begin
                            if (tick[c] == atx_div(ctrl1_r[c]) - 7'h01) begin
                                tick[c] <= 7'h00;
                                if (gap[c] == `ATX_GAP_BITS - 3'h1)
                                    st[c] <= ST_IDLE;
                                else
                                    gap[c] <= gap[c] + 3'h1;
                            end else begin
                                tick[c] <= tick[c] + 7'h01;
                            end
                        end
                        default: st[c] <= ST_IDLE;
                    endcase
                end
            end
        end
    end
    assign tx_hi_o = hi_r;
    assign tx_lo_o = lo_r;

    // wraparound copies; swapping legs inverts the odd receivers
    reg [3:0] wh_r;                             // looped high legs
    reg [3:0] wl_r;                             // looped low legs
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wh_r <= 4'h0;
            wl_r <= 4'h0;
        end else begin
            for (j = 0; j < 2; j = j + 1) begin
                wh_r[2*j]   <= ctrl1_r[`ATX_C1_WRAP+j] & hi_r[j];
                wl_r[2*j]   <= ctrl1_r[`ATX_C1_WRAP+j] & lo_r[j];
                wh_r[2*j+1] <= ctrl1_r[`ATX_C1_WRAP+j] & lo_r[j];
                wl_r[2*j+1] <= ctrl1_r[`ATX_C1_WRAP+j] & hi_r[j];
            end
        end
    end
    assign wrap_hi_o = wh_r;
    assign wrap_lo_o = wl_r;

    // interrupt sources: match, queue 0 empties, queue 1 empties
    reg  [1:0] empty_d_r;                       // empty, delayed
    wire [1:0] drain = empty & ~empty_d_r;      // queue just went empty
    reg  [8:0] ev;                              // events per output

    // route every source to its output; route zero reaches none
    always @* begin
        ev = 9'h000;
        for (m = 0; m < 3; m = m + 1) begin
            ev[3*m]   = match_i & atx_hit(match_route_i, m[1:0] + 2'h1);
            ev[3*m+1] = drain[0] & atx_hit(iroute_r[1:0], m[1:0] + 2'h1);
            ev[3*m+2] = drain[1] & atx_hit(iroute_r[3:2], m[1:0] + 2'h1);
        end
    end

    reg [4:0] pcnt [0:2];                       // pulse countdown
    reg [2:0] irq_n_r;                          // output flops

    // status latches regardless of mask; a new event beats the read clear
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            empty_d_r <= 2'h3;
            istat_r   <= 9'h000;
            irq_n_r   <= 3'h7;
            for (k = 0; k < 3; k = k + 1)
                pcnt[k] <= 5'h00;
        end else begin
            empty_d_r <= empty;
            istat_r <= (istat_r & ~{{3{ist_clr[2]}}, {3{ist_clr[1]}}, {3{ist_clr[0]}}})
                     | ev;
            for (k = 0; k < 3; k = k + 1) begin
                // each unmasked event restarts the pulse
                if (imode_r[k] && (|ev[3*k +: 3]) && !imask_r[k])
                    pcnt[k] <= PULSE_CYC[4:0];
                else if (pcnt[k] != 5'h00)
                    pcnt[k] <= pcnt[k] - 5'h01;
                if (imode_r[k])
                    irq_n_r[k] <= (pcnt[k] == 5'h00);
                else
                    irq_n_r[k] <= ~((|istat_r[3*k +: 3]) & ~imask_r[k]);
            end
        end
    end
    assign irq_n_o = irq_n_r;

    // error bits: inputs set on a rising condition, cleared by read or removal; overflow bits set on a refused push, cleared by read
    wire [5:0] err_nxt;                         // next error status
    assign err_nxt[3:0] = (err_r[3:0] & ~{4{err_clr}} & esy) | (esy & ~err_d_r);
    assign err_nxt[5:4] = (err_r[5:4] & ~{2{err_clr}}) | ovf;
    reg err_n_r;                                // error pin flop

    // error output has no mask at all
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err_r   <= 6'h00;
            err_n_r <= 1'b1;
        end else begin
            err_r   <= err_nxt;
            err_n_r <= ~(|err_nxt);
        end
    end
    assign error_n_o = err_n_r;

endmodule // atx_tx_irq

/* dv/atx_monitor.sv */
// port-level assertion checker for the transmit and interrupt block
`timescale 1ns/1ps
module atx_monitor (
    input wire        clock_i, nrst_i, host_rd_i, mem_rd_o, error_n_o,
    input wire [10:0] host_addr_i,
    input wire [15:0] host_rdata_o,
    input wire [1:0]  tx_hi_o, tx_lo_o,
    input wire [3:0]  wrap_hi_o, wrap_lo_o, error_i,
    input wire [2:0]  irq_n_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_err_on; error_i[0] [*7]; endsequence
    sequence s_irq_low; !irq_n_o[0] [*8]; endsequence
    a_rd_quiet: assert property (!$past(host_rd_i) |-> host_rdata_o == 16'h0000)
        else $error("read data outside answer cycle");
    a_mem_fetch: assert property (mem_rd_o |-> host_rd_i && host_addr_i[10])
        else $error("stray memory fetch");
    a_leg_excl: assert property ((tx_hi_o & tx_lo_o) == 2'b00)
        else $error("both line legs high");
    a_wrap_inv0: assert property (wrap_hi_o[1] == wrap_lo_o[0] && wrap_lo_o[1] == wrap_hi_o[0])
        else $error("loop one not inverted");
    a_wrap_inv1: assert property (wrap_hi_o[3] == wrap_lo_o[2] && wrap_lo_o[3] == wrap_hi_o[2])
        else $error("loop three not inverted");
    a_err_held: assert property (s_err_on |-> !error_n_o)
        else $error("error pin high while fault present");
    a_err_rise: assert property ($rose(error_i[1]) |-> ##[1:6] !error_n_o)
        else $error("error pin slow to assert");
    a_irq_hold: assert property ($fell(irq_n_o[0]) |-> s_irq_low)
        else $error("interrupt pulse too short");
endmodule // atx_monitor
bind atx_tx_irq atx_monitor u_mon (.clock_i, .nrst_i, .host_rd_i, .mem_rd_o, .error_n_o,
    .host_addr_i, .host_rdata_o, .tx_hi_o, .tx_lo_o, .wrap_hi_o, .wrap_lo_o, .error_i, .irq_n_o);

/* dv/atx_far_model.sv */
// far side: free bit clock sources and the shared memory word source
`timescale 1ns/1ps
module atx_far_model (
    input  wire logic        mem_rd_i,
    input  wire logic [9:0]  mem_addr_i,
    output logic      [31:0] mem_data_o,
    output logic      [1:0]  bit_clk_o
);
    initial bit_clk_o = 2'b00;
    always #500 bit_clk_o[0] = ~bit_clk_o[0]; // 1 MHz source
    always #487 bit_clk_o[1] = ~bit_clk_o[1]; // unrelated phase
    // unselected memory shows junk so a stale sample cannot pass
    always @* mem_data_o = mem_rd_i ? {~mem_addr_i, 6'h2a, mem_addr_i, 6'h15} : 32'h5a5a_a5a5;
endmodule // atx_far_model

/* dv/tb_top.sv */
// self-checking bench for the transmit and interrupt block
`timescale 1ns/1ps
`include "atx_defs.vh"
`define CHK(g,e) begin checked++; if ((g) !== (e)) begin err_count++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    logic clock_i = 0, nrst_i = 0, host_wr_i = 0, host_rd_i = 0, match_i = 0, mrd, error_n_o;
    logic [10:0] host_addr_i = 0;
    logic [15:0] host_wdata_i = 0, d, host_rdata_o;
    logic [1:0] match_route_i = 0, tx_hi_o, tx_lo_o, bclk;
    logic [3:0] error_i = 0, wrap_hi_o, wrap_lo_o;
    logic [2:0] irq_n_o;
    logic bus8 = 0;
    logic [31:0] w, got, mdat;
    logic [9:0] maddr;
    int err_count = 0, checked = 0, n[3], k;
    always #25 clock_i = ~clock_i;
    atx_tx_irq dut (.clock_i, .nrst_i, .host_addr_i, .host_wdata_i, .host_wr_i, .host_rd_i,
        .host_rdata_o, .strobe_style_i(1'b0), .bus_8bit_i(bus8), .zero_wait_i(1'b1),
        .arinc_clk_i(bclk), .tx_hi_o, .tx_lo_o, .wrap_hi_o, .wrap_lo_o, .match_i, .match_route_i,
        .error_i, .mem_rd_o(mrd), .mem_addr_o(maddr), .mem_data_i(mdat), .irq_n_o, .error_n_o);
    atx_far_model far (.mem_rd_i(mrd), .mem_addr_i(maddr), .mem_data_o(mdat), .bit_clk_o(bclk));
    task automatic wr(input [10:0] a, input [15:0] v);
        @(posedge clock_i); host_addr_i <= a; host_wdata_i <= v; host_wr_i <= 1;
        @(posedge clock_i); host_wr_i <= 0;
    endtask
    task automatic rd(input [10:0] a);
        @(posedge clock_i); host_addr_i <= a; host_rd_i <= 1;
        @(posedge clock_i); host_rd_i <= 0;
        #1 d = host_rdata_o;
    endtask
    task automatic event_on(input [1:0] r);
        @(posedge clock_i); match_i <= 1; match_route_i <= r;
        @(posedge clock_i); match_i <= 0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        void'($urandom(91609));
        repeat (8) @(posedge clock_i);
        nrst_i <= 1;
        repeat (3) @(posedge clock_i);
        rd(`ATX_A_CTRL2); `CHK(d, 16'h0003)
        rd(11'h3ff); `CHK(d, 16'h0000)
        for (int np = 0; np < 2; np++) begin
            w = $urandom;
            wr(`ATX_A_CTRL1, np ? 16'h0015 : 16'h0005);
            wr(`ATX_A_TX0_LO, w[15:0]);
            wr(`ATX_A_TX0_HI, w[31:16]);
            rd(`ATX_A_STAT); `CHK(d[0], 1'b0)
            wr(`ATX_A_CTRL2, 16'h0002); // enable channel zero only
            for (k = 0; k < 4000 && !(tx_hi_o[0] | tx_lo_o[0]); k++) @(posedge clock_i);
            if (k == 4000) begin err_count++; give_verdict; end
            repeat (50) @(posedge clock_i); // middle of the active half bit
            `CHK({wrap_hi_o[1:0], ~wrap_lo_o[1:0]}, {2{~w[0], w[0]}})
            for (int b = 0; b < 32; b++) begin got[b] = tx_hi_o[0]; repeat (200) @(posedge clock_i); end
            `CHK(got, np ? w : {~^w[30:0], w[30:0]})
            wr(`ATX_A_CTRL2, 16'h0003);
            rd(`ATX_A_STAT); `CHK(d[0], 1'b1)
        end
        $display("transmit test done");
        @(posedge clock_i); error_i <= 4'h3;
        repeat (12) @(posedge clock_i); `CHK(error_n_o, 1'b0)
        error_i <= 4'h0;
        repeat (8) @(posedge clock_i); `CHK(error_n_o, 1'b1)
        repeat (33) begin wr(`ATX_A_TX1_LO, 16'h1234); wr(`ATX_A_TX1_HI, 16'h0042); end
        rd(`ATX_A_STAT); `CHK(d[3], 1'b1)
        `CHK(error_n_o, 1'b0)
        rd(`ATX_A_ERR); `CHK(d[5], 1'b1)
        repeat (3) @(posedge clock_i); `CHK(error_n_o, 1'b1)
        $display("error test done");
        event_on(2'h1); repeat (12) @(posedge clock_i); `CHK(irq_n_o, 3'b110)
        rd(`ATX_A_ISTAT1); `CHK(d[0], 1'b1)
        repeat (2) @(posedge clock_i); `CHK(irq_n_o, 3'b111)
        wr(`ATX_A_IMASK, 16'h0001);
        event_on(2'h1); repeat (12) @(posedge clock_i); `CHK(irq_n_o, 3'b111)
        wr(`ATX_A_IMASK, 16'h0000);
        repeat (9) @(posedge clock_i); `CHK(irq_n_o, 3'b110)
        rd(`ATX_A_ISTAT1);
        wr(`ATX_A_IMASK, 16'h0001); event_on(2'h1); rd(`ATX_A_ISTAT1);
        wr(`ATX_A_IMASK, 16'h0000); repeat (3) @(posedge clock_i); `CHK(irq_n_o, 3'b111)
        wr(`ATX_A_IMODE, 16'h0007);
        for (int r = 0; r < 4; r++) begin
            event_on(r[1:0]);
            n = '{0, 0, 0};
            repeat (40) begin @(posedge clock_i); for (k = 0; k < 3; k++) n[k] += (irq_n_o[k] === 1'b0); end
            for (k = 0; k < 3; k++) `CHK(n[k], (r == k + 1) ? 20 : 0)
        end
        $display("interrupt test done");
        rd(11'h400); `CHK(d, 16'h0000)
        rd(11'h400); `CHK(d, 16'h0015)
        rd(11'h401); `CHK(d, 16'hffea)
        bus8 <= 1; w = 32'hffea_0015; repeat (3) @(posedge clock_i);
        for (k = 0; k < 5; k++) begin
            rd(11'h400 + k - (k > 0)); `CHK(d, k ? {8'h00, w[8*k-8 +: 8]} : 16'h0000)
        end
        $display("zero wait test done");
        give_verdict;
    end
endmodule // tb_top
